// File: wsp_pkg.sv
// package: constants and types for the wait/stop power mode controller
package wsp_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] WSP_CTRL_ADDR = 8'h00;
    localparam logic [7:0] WSP_CLKSEL_ADDR = 8'h04;
    localparam logic [7:0] WSP_SRC_ADDR = 8'h08;
    localparam logic [7:0] WSP_STATUS_ADDR = 8'h0c;
    localparam logic [7:0] WSP_CMD_ADDR = 8'h10;

    // ctrl fields
    localparam int WSP_CTRL_PCSW_BIT = 0;
    localparam int WSP_CTRL_DIV8_BIT = 1;
    localparam int WSP_CTRL_HDRV_BIT = 2;
    localparam int WSP_CTRL_SUBCPU_BIT = 3;
    localparam int WSP_CTRL_CLKO_LSB = 4;
    // cmd fields: write 1 to act
    localparam int WSP_CMD_STOP_BIT = 0;

    // reset values: cpu runs main clock divided by 8
    localparam logic [31:0] WSP_CTRL_RST = 32'h0000_0002;
    localparam logic [31:0] WSP_SRC_RST = 32'h0000_0000;

    // source config bits (per-source qualifiers)
    localparam int WSP_SRC_SER_EXT_BIT = 0;
    localparam int WSP_SRC_AD_ONESHOT_BIT = 1;
    localparam int WSP_SRC_TMR_EVT_BIT = 2;
    localparam int WSP_SRC_TMR_C32_BIT = 3;

    // clock output select codes
    localparam logic [1:0] WSP_CLKO_OFF = 2'h0;
    localparam logic [1:0] WSP_CLKO_SUB = 2'h1;
    localparam logic [1:0] WSP_CLKO_DIV8 = 2'h2;
    localparam logic [1:0] WSP_CLKO_DIV32 = 2'h3;

    // divider lengths for the generated peripheral taps
    localparam int WSP_DIV8_CNT = 8;
    localparam int WSP_DIV32_CNT = 32;

    typedef enum logic [2:0] {
        WSP_RUN = 3'b001,
        WSP_WAIT = 3'b010,
        WSP_STOP = 3'b100
    } wsp_state_t;
endpackage

// File: wsp_power_ctrl.sv
// module: wait and stop power mode controller with apb registers
`timescale 1ns/1ns
// ************************************************************
// ************************************************************
module wsp_power_ctrl
    import wsp_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int BUS_W = 16
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic sleep_instr_in,
    input wire logic irq_pending_in,
    input wire logic key_irq_in,
    input wire logic pin_irq_in,
    input wire logic serial_irq_in,
    input wire logic converter_irq_in,
    input wire logic timer_irq_in,
    input wire logic [BUS_W-1:0] bus_drive_in,
    output logic main_osc_en_out,
    output logic sub_osc_en_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic subclk_div32_clock_en_out,
    output logic wake_irq_out,
    output logic clock_output_pin_out,
    output logic [BUS_W-1:0] bus_hold_out,
    output logic bus_strobe_n_out,
    output logic bus_latch_out
);
    // ************************************************************
    // state and registers
    // ************************************************************
    // one-hot state; the status word reads it back as is
    wsp_state_t state_reg, state_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] src_reg, src_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [4:0] div_reg, div_next;
    logic c32_reg, c32_next;
    logic clko_reg, clko_next;
    logic [BUS_W-1:0] bus_reg, bus_next;
    logic cpu_en_reg, cpu_en_next;
    logic per_en_reg, per_en_next;
    logic osc_reg, osc_next;
    logic wake_reg, wake_next;
    logic strobe_n_reg, strobe_n_next;
    logic latch_reg, latch_next;

    logic pcsw;
    logic wr_acc;
    logic rd_acc;
    logic wait_wake;
    logic stop_wake;

    function automatic logic [31:0] wsp_rd_mux(input logic [ADDR_W-1:0] a,
                                               input logic [31:0] c,
                                               input logic [31:0] s,
                                               input wsp_state_t st);
        case (a)
            WSP_CTRL_ADDR[ADDR_W-1:0]: wsp_rd_mux = c;
            WSP_SRC_ADDR[ADDR_W-1:0]: wsp_rd_mux = s;
            WSP_STATUS_ADDR[ADDR_W-1:0]: wsp_rd_mux = {29'h0, st};
            default: wsp_rd_mux = 32'h0;
        endcase
    endfunction

    // the reserved clock select word decodes but always reads zero
    function automatic logic wsp_mapped(input logic [ADDR_W-1:0] a);
        wsp_mapped = (a == WSP_CTRL_ADDR[ADDR_W-1:0]) || (a == WSP_CLKSEL_ADDR[ADDR_W-1:0])
            || (a == WSP_SRC_ADDR[ADDR_W-1:0]) || (a == WSP_STATUS_ADDR[ADDR_W-1:0])
            || (a == WSP_CMD_ADDR[ADDR_W-1:0]);
    endfunction

    assign pcsw = ctrl_reg[WSP_CTRL_PCSW_BIT];
    assign wr_acc = psel_in && penable_in && pwrite_in && !pready_reg;
    assign rd_acc = psel_in && penable_in && !pwrite_in && !pready_reg;

    // ************************************************************
    // wake qualification
    // ************************************************************
    always_comb begin
        // key and pin interrupts are externally clocked, always usable
        wait_wake = key_irq_in || pin_irq_in;
        if (!pcsw) begin
            wait_wake = wait_wake || irq_pending_in || serial_irq_in || timer_irq_in;
            wait_wake = wait_wake
                || (converter_irq_in && src_reg[WSP_SRC_AD_ONESHOT_BIT]);
        end else begin
            // converter clock is gated here, so its request can never qualify
            wait_wake = wait_wake
                || (serial_irq_in && src_reg[WSP_SRC_SER_EXT_BIT])
                || (timer_irq_in && (src_reg[WSP_SRC_TMR_EVT_BIT]
                    || src_reg[WSP_SRC_TMR_C32_BIT]));
        end
        // with every oscillator off only sources clocked from outside can request
        stop_wake = key_irq_in || pin_irq_in
            || (timer_irq_in && src_reg[WSP_SRC_TMR_EVT_BIT])
            || (serial_irq_in && src_reg[WSP_SRC_SER_EXT_BIT]);
    end

    // ************************************************************
    // mode sequencer and register writes
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        ctrl_next = ctrl_reg;
        src_next = src_reg;
        wake_next = 1'b0;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        // one wait state: ready rises after the first access cycle, for any address
        if (psel_in && penable_in && !pready_reg) begin
            pready_next = 1'b1;
            pslverr_next = !wsp_mapped(paddr_in);
        end
        if (rd_acc) begin
            prdata_next = wsp_rd_mux(paddr_in, ctrl_reg, src_reg, state_reg);
        end
        // writes outside run complete normally but change nothing
        if (wr_acc && state_reg == WSP_RUN) begin
            case (paddr_in)
                WSP_CTRL_ADDR[ADDR_W-1:0]: ctrl_next = {24'h0, pwdata_in[7:0]};
                WSP_SRC_ADDR[ADDR_W-1:0]: src_next = {28'h0, pwdata_in[3:0]};
                WSP_CMD_ADDR[ADDR_W-1:0]: begin
                    if (pwdata_in[WSP_CMD_STOP_BIT]) begin
                        state_next = WSP_STOP;
                        ctrl_next[WSP_CTRL_DIV8_BIT] = 1'b1;
                        ctrl_next[WSP_CTRL_HDRV_BIT] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // a stop command beats a sleep strobe arriving in the same cycle
        case (state_reg)
            WSP_RUN: begin
                if (sleep_instr_in && state_next == WSP_RUN) begin
                    state_next = WSP_WAIT;
                end
            end
            WSP_WAIT: begin
                if (wait_wake) begin
                    // clock source and divider are untouched, so cpu resumes as before
                    state_next = WSP_RUN;
                    wake_next = 1'b1;
                end
            end
            WSP_STOP: begin
                if (stop_wake) begin
                    // div8 was already forced at entry; sub clock select is kept
                    state_next = WSP_RUN;
                    wake_next = 1'b1;
                end
            end
            default: state_next = WSP_RUN;
        endcase
    end

    // ************************************************************
    // clock enables, taps and pin hold
    // ************************************************************
    always_comb begin
        // enables follow the next state so the gate closes on the entry edge itself
        cpu_en_next = (state_next == WSP_RUN);
        osc_next = (state_next != WSP_STOP);
        per_en_next = (state_next == WSP_RUN)
            || (state_next == WSP_WAIT && !ctrl_next[WSP_CTRL_PCSW_BIT]);
        div_next = div_reg;
        c32_next = c32_reg;
        // the divider runs on in wait so the taps resume in phase after wake
        if (osc_reg) begin
            div_next = div_reg + 5'h1;
            // the c32 tap runs on any state but stop, regardless of the gate bit
            c32_next = (div_reg == 5'h1f);
        end else begin
            c32_next = 1'b0;
        end
        clko_next = clko_reg;
        // prescaler taps freeze with the peripheral gate; the sub clock keeps toggling until stop turns the oscillators off
        case (ctrl_reg[WSP_CTRL_CLKO_LSB +: 2])
            WSP_CLKO_SUB: begin
                if (osc_reg) begin
                    clko_next = !clko_reg;
                end
            end
            WSP_CLKO_DIV8: begin
                if (per_en_reg && div_reg[2:0] == 3'(WSP_DIV8_CNT - 1)) begin
                    clko_next = !clko_reg;
                end
            end
            WSP_CLKO_DIV32: begin
                if (per_en_reg && div_reg == 5'(WSP_DIV32_CNT - 1)) begin
                    clko_next = !clko_reg;
                end
            end
            default: clko_next = 1'b0;
        endcase
        // pins follow the registered state, so they park one cycle after the cpu gate
        if (state_reg == WSP_RUN) begin
            bus_next = bus_drive_in;
            strobe_n_next = 1'b0;
            latch_next = 1'b1;
        end else begin
            // hold address/data/selects, park strobes high and latch low
            bus_next = bus_reg;
            strobe_n_next = 1'b1;
            latch_next = 1'b0;
        end
    end

    // ************************************************************
    // register stage
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            // back to run, cpu on the main clock divided by 8
            state_reg <= WSP_RUN;
            ctrl_reg <= WSP_CTRL_RST;
            src_reg <= WSP_SRC_RST;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            wake_reg <= 1'b0;
            div_reg <= 5'h0;
            c32_reg <= 1'b0;
            clko_reg <= 1'b0;
            bus_reg <= '0;
            cpu_en_reg <= 1'b1;
            per_en_reg <= 1'b1;
            osc_reg <= 1'b1;
            strobe_n_reg <= 1'b1;
            latch_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            src_reg <= src_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            wake_reg <= wake_next;
            div_reg <= div_next;
            c32_reg <= c32_next;
            clko_reg <= clko_next;
            bus_reg <= bus_next;
            cpu_en_reg <= cpu_en_next;
            per_en_reg <= per_en_next;
            osc_reg <= osc_next;
            strobe_n_reg <= strobe_n_next;
            latch_reg <= latch_next;
        end
    end

    // ************************************************************
    // outputs, each straight from a flip-flop
    // ************************************************************
    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign main_osc_en_out = osc_reg;
    assign sub_osc_en_out = osc_reg;
    assign cpu_clk_en_out = cpu_en_reg;
    assign periph_clk_en_out = per_en_reg;
    assign subclk_div32_clock_en_out = c32_reg;
    assign wake_irq_out = wake_reg;
    assign clock_output_pin_out = clko_reg;
    assign bus_hold_out = bus_reg;
    assign bus_strobe_n_out = strobe_n_reg;
    assign bus_latch_out = latch_reg;
endmodule

// File: wsp_power_ctrl_asserts.sv
// checker: port-level properties of the wait/stop power mode controller
`timescale 1ns/1ns
module wsp_power_ctrl_asserts #(parameter int BUS_W = 16) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic sleep_instr_in,
    input wire logic main_osc_en_out,
    input wire logic sub_osc_en_out,
    input wire logic cpu_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic wake_irq_out,
    input wire logic [BUS_W-1:0] bus_hold_out,
    input wire logic bus_strobe_n_out,
    input wire logic bus_latch_out
);
    // ********************
    // properties
    // ********************
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    property p_sleep; $rose(sleep_instr_in) && cpu_clk_en_out |-> ##1 !cpu_clk_en_out; endproperty
    a_sleep: assert property (p_sleep) else $error("cpu clock kept after sleep");
    // the parked strobe follows the cpu clock gate one cycle later, on entry and on wake
    property p_wait; !$past(srst_in) |-> bus_strobe_n_out == !$past(cpu_clk_en_out); endproperty
    a_wait: assert property (p_wait) else $error("cpu clock on while bus parked");
    property p_osc; main_osc_en_out == sub_osc_en_out; endproperty
    a_osc: assert property (p_osc) else $error("oscillators disagree");
    property p_off; !main_osc_en_out |-> !cpu_clk_en_out && !periph_clk_en_out; endproperty
    a_off: assert property (p_off) else $error("clock on with oscillators off");
    property p_periph; !periph_clk_en_out |-> !cpu_clk_en_out; endproperty
    a_periph: assert property (p_periph) else $error("peripheral clock off in run");
    property p_wake; wake_irq_out |-> cpu_clk_en_out ##1 !wake_irq_out; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse without cpu clock");
    property p_pins; bus_strobe_n_out == !bus_latch_out; endproperty
    a_pins: assert property (p_pins) else $error("strobe and latch levels disagree");
    property p_hold; !$past(srst_in) && bus_strobe_n_out && $past(bus_strobe_n_out)
        |-> $stable(bus_hold_out); endproperty
    a_hold: assert property (p_hold) else $error("bus pins moved while parked");
endmodule
bind wsp_power_ctrl wsp_power_ctrl_asserts #(.BUS_W(BUS_W)) u_chk(.*);

// File: wsp_cpu_model.sv
// partner model: cpu sleep strobe and interrupt controller request lines
`timescale 1ns/1ns
module wsp_cpu_model (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic sleep_req_in,
    input wire logic [5:0] irq_req_in,
    input wire logic wake_irq_in,
    output logic sleep_instr_out,
    output logic [5:0] irq_out
);
    // ********************
    // cpu and interrupt controller
    // ********************
    // a request stays up until serviced, like a latched interrupt flag
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sleep_instr_out <= 1'b0;
            irq_out <= 6'h00;
        end else begin
            sleep_instr_out <= sleep_req_in;
            irq_out <= wake_irq_in ? 6'h00 : irq_out | irq_req_in;
        end
    end
endmodule

// File: tb_wsp_power_ctrl.sv
// testbench: register, wait and stop scenarios for the power mode controller
`timescale 1ns/1ns
module tb_wsp_power_ctrl;
    // ********************
    // signals, design and partner
    // ********************
    logic clock_in = 0, srst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, slp = 0;
    logic [7:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, q;
    logic pready_out, pslverr_out, sleep_instr_in, e, irq_pending_in, key_irq_in, pin_irq_in;
    logic serial_irq_in, converter_irq_in, timer_irq_in, main_osc_en_out, sub_osc_en_out;
    logic cpu_clk_en_out, periph_clk_en_out, subclk_div32_clock_en_out, wake_irq_out;
    logic clock_output_pin_out, bus_strobe_n_out, bus_latch_out;
    logic [15:0] bus_drive_in = 0, bus_hold_out, h;
    logic [5:0] irq = 0, irq_v;
    int checks = 0, miscompares = 0;
    // ctrl byte, src nibble, interrupt index, wake expected
    logic [15:0] tbl [12] = '{16'h0001, 16'h1100, 16'h2106, 16'h3117, 16'h2007, 16'h0128,
        16'h0829, 16'h0008, 16'h010a, 16'h014b, 16'h018b, 16'h0105};
    assign {timer_irq_in, converter_irq_in, serial_irq_in, pin_irq_in, key_irq_in,
        irq_pending_in} = irq_v;
    wsp_power_ctrl u_dut(.*);
    wsp_cpu_model u_cpu(.clock_in(clock_in), .srst_in(srst_in), .sleep_req_in(slp),
        .irq_req_in(irq), .wake_irq_in(wake_irq_out), .sleep_instr_out(sleep_instr_in),
        .irq_out(irq_v));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) bus_drive_in <= bus_drive_in + 16'h1;
    // the run needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        final_report;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in) penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("read", q, x);
    endtask
    task automatic poke(input logic [5:0] v, output logic woke);
        irq <= v;
        @(posedge clock_in) irq <= 6'h0;
        for (int n = 0; n < 8 && wake_irq_out !== 1'b1; n++) @(posedge clock_in);
        woke = wake_irq_out;
    endtask
    task automatic t_regs;
        rdc(8'h00, 32'h2);
        rdc(8'h0c, 32'h1);
        rdc(8'h04, 32'h0);
        chk("mapped_err", e, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", e, 1'b1);
        chk("unmapped_data", q, 32'h0);
        $display("test registers done");
    endtask
    task automatic t_wait(input logic [15:0] t);
        logic w;
        logic p;
        int nt, nc, ex;
        apb(1'b1, 8'h00, {24'h0, t[15:8]});
        apb(1'b1, 8'h08, {28'h0, t[7:4]});
        slp <= 1'b1;
        @(posedge clock_in) slp <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk("cpu_en", cpu_clk_en_out, 1'b0);
        chk("periph_en", periph_clk_en_out, !t[8]);
        chk("osc_en", main_osc_en_out & sub_osc_en_out, 1'b1);
        h = bus_hold_out;
        apb(1'b1, 8'h00, 32'hff);
        chk("bus", {bus_strobe_n_out, bus_latch_out, bus_hold_out}, {2'b10, h});
        // sub clock always toggles; prescaler taps only while the gate bit is clear
        ex = 0;
        if (t[13:12] == 2'h1)
            ex = 32;
        else if (!t[8] && t[13:12] == 2'h2)
            ex = 4;
        else if (!t[8] && t[13:12] == 2'h3)
            ex = 1;
        p = clock_output_pin_out;
        nt = 0;
        nc = 0;
        repeat (32) begin
            @(posedge clock_in);
            nt += (clock_output_pin_out !== p);
            nc += subclk_div32_clock_en_out;
            p = clock_output_pin_out;
        end
        chk("c32_pulses", nc, 32'h1);
        chk("clko_toggles", nt, ex);
        poke(6'h01 << t[3:1], w);
        chk("woken", w, t[0]);
        if (w !== 1'b1)
            poke(6'h02, w);
        chk("cpu_en", cpu_clk_en_out, 1'b1);
        rdc(8'h00, {24'h0, t[15:8]});
        $display("test wait %h done", t);
    endtask
    task automatic t_stop(input logic [7:0] c);
        logic w;
        apb(1'b1, 8'h00, {24'h0, c});
        apb(1'b1, 8'h10, 32'h1);
        @(posedge clock_in);
        chk("clocks", {main_osc_en_out, cpu_clk_en_out, periph_clk_en_out}, 3'h0);
        rdc(8'h0c, 32'h4);
        rdc(8'h00, {24'h0, c | 8'h06});
        poke(6'h21, w);
        chk("woken", w, 1'b0);
        poke(6'h04, w);
        chk("woken", w, 1'b1);
        rdc(8'h00, {24'h0, c | 8'h06});
        $display("test stop %h done", c);
    endtask
    task automatic t_rst;
        slp <= 1'b1;
        @(posedge clock_in) slp <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk("cpu_en", cpu_clk_en_out, 1'b0);
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        chk("cpu_en", cpu_clk_en_out, 1'b1);
        rdc(8'h0c, 32'h1);
        rdc(8'h00, 32'h2);
        $display("test reset wake done");
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        t_regs;
        foreach (tbl[k]) t_wait(tbl[k]);
        t_stop(8'h08);
        t_stop(8'h00);
        t_rst;
        final_report;
    end
endmodule
